/* File: bench/qpc_enc_model.sv */
// Rotary encoder model driving the A and B phase lines of one pair.
// Assumes the bench holds step or skip high for one clock, set at a falling edge.
module qpc_enc_model (
   input wire logic clk, // Bench clock.
   input wire logic step, // Advance one quadrature state.
   input wire logic skip, // Jump two states, so both lines change together.
   input wire logic fwd, // High to turn with A leading B.
   output logic a, // Phase A line.
   output logic b // Phase B line.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] pos_q = 2'h0;
   always @(negedge clk) begin
      if (skip) begin
         pos_q <= pos_q + 2'h2;
      end else if (step) begin
         pos_q <= fwd ? pos_q + 2'h1 : pos_q - 2'h1;
      end
   end
   // Gray order changes one line per step, so no step looks like a double change.
   assign a = pos_q[1] ^ pos_q[0];
   assign b = pos_q[1];
endmodule

/* File: bench/qpc_quadrature_pulse_counter_tb.sv */
// Self-checking bench: pair 0 decodes the encoder model, pair 1 counts pulses.
// Assumes the count latencies and encodings given by the package.
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module qpc_quadrature_pulse_counter_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import qpc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic scan_start = 1'b0;
   logic step = 1'b0;
   logic skip = 1'b0;
   logic fwd = 1'b1;
   logic [1:0] tly = 2'h0;
   logic enc_a, enc_b;
   logic [3:0][2:0] term_fn = {4{QPC_FN_QUAD}};
   logic [1:0][1:0] quad_mode = 4'h0;
   logic [1:0][31:0] quad_net, quad_fwd, quad_rev;
   logic [1:0] quad_dir_fwd, pair_conflict;
   logic [3:0][31:0] tally_value;
   logic tally_valid;
   logic [1:0] rp = 2'h0;
   int errors = 0, check_count = 0, seed = 32'h044b_11a6, en = 0, ef = 0, er = 0, n, m;
   qpc_mode_t modes [3] = '{QPC_MODE_X1, QPC_MODE_X2, QPC_MODE_X4};
   qpc_fn_t bad [3] = '{QPC_FN_EDGE_TIMING, QPC_FN_EDGE_TALLY, QPC_FN_TRIG_WAIT};
   always #25 clk = ~clk;
   qpc_enc_model enc (.clk(clk), .step(step), .skip(skip), .fwd(fwd), .a(enc_a), .b(enc_b));
   qpc_quadrature_pulse_counter #(.NUM_PAIRS(2)) uut (.clk(clk), .rst(rst),
      .term_in({tly, enc_b, enc_a}), .scan_start(scan_start), .term_fn(term_fn),
      .quad_mode(quad_mode), .quad_net(quad_net), .quad_dir_fwd(quad_dir_fwd),
      .quad_fwd(quad_fwd), .quad_rev(quad_rev), .tally_value(tally_value),
      .tally_valid(tally_valid), .pair_conflict(pair_conflict));
   // ****************************************
   // Shared tasks
   // ****************************************
   // A jolt moves the encoder two states at once; the decoder must drop it.
   task automatic turn(input logic f, input qpc_mode_t md, input logic j = 1'b0);
      logic [1:0] np;
      logic ea;
      np = j ? rp + 2'h2 : f ? rp + 2'h1 : rp - 2'h1;
      ea = (rp[1] ^ rp[0]) != (np[1] ^ np[0]);
      if (!j && (md == QPC_MODE_X4 ||
          (ea && (md == QPC_MODE_X2 || f == (np[1] ^ np[0]))))) begin
         en += f ? 1 : -1;
         ef += f;
         er += !f;
      end
      rp = np;
      fwd <= f;
      step <= !j;
      skip <= j;
      @(negedge clk);
      step <= 1'b0;
      skip <= 1'b0;
      repeat (8) @(negedge clk);
      `CHK("net", 32'(en), quad_net[0])
      `CHK("fwd", 32'(ef), quad_fwd[0])
      `CHK("rev", 32'(er), quad_rev[0])
      `CHK("dir", en > 0, quad_dir_fwd[0])
   endtask
   task automatic pulses(input int k, input int t);
      repeat (k) begin
         tly[t] <= 1'b1;
         repeat (4) @(negedge clk);
         tly[t] <= 1'b0;
         repeat (4) @(negedge clk);
      end
   endtask
   task automatic scan(input int e2, input int e3);
      scan_start <= 1'b1;
      @(negedge clk) scan_start <= 1'b0;
      `CHK("valid", 1'b1, tally_valid)
      `CHK("tally2", 32'(e2), tally_value[2])
      `CHK("tally3", 32'(e3), tally_value[3])
      `CHK("tally0", 32'h0000_0000, tally_value[0])
      @(negedge clk);
      `CHK("valid", 1'b0, tally_valid)
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      end_of_test();
   end
   initial begin
      repeat (6) @(negedge clk);
      rst <= 1'b0;
      repeat (4) @(negedge clk);
      foreach (modes[i]) begin
         quad_mode[0] <= modes[i];
         repeat (8) turn(1'b1, modes[i]);
         turn(1'b1, modes[i], 1'b1);
         repeat (12) turn(1'b0, modes[i]);
         $display("decode mode %0d done", i);
      end
      term_fn[3:2] <= {2{QPC_FN_EDGE_TALLY}};
      repeat (3) @(negedge clk);
      scan(0, 0);
      repeat (3) begin
         n = 1 + ($unsigned($random(seed)) % 8);
         m = $unsigned($random(seed)) % 8;
         pulses(n, 0);
         pulses(m, 1);
         repeat (8) @(negedge clk);
         scan(n, m);
         scan(0, 0);
      end
      `CHK("net1", 32'h0000_0000, quad_net[1])
      $display("tally done");
      foreach (bad[i]) begin
         term_fn[3:2] <= {bad[i], QPC_FN_SERIAL_REC};
         repeat (3) @(negedge clk);
         `CHK("conflict1", 1'b1, pair_conflict[1])
         `CHK("conflict0", 1'b0, pair_conflict[0])
         term_fn[3:2] <= {QPC_FN_SERIAL_REC, bad[i]};
         repeat (3) @(negedge clk);
         `CHK("conflict1", 1'b1, pair_conflict[1])
         term_fn[3:2] <= {QPC_FN_SERIAL_REC, QPC_FN_IDLE};
         repeat (3) @(negedge clk);
         `CHK("conflict1", 1'b0, pair_conflict[1])
      end
      $display("conflict done");
      end_of_test();
   end
endmodule

/* File: hw/qpc_quadrature_pulse_counter.sv */
// Quadrature decoders over adjacent terminal pairs, plus per-terminal scan pulse counters.
// Assumes terminals are asynchronous pins and scan_start is a one-cycle pulse on clk.
// Notes on behaviour
// - Net count rises when A leads B, falls when B leads A.
// - Report net direction and separate A-leading and B-leading totals.
// - Lowest resolution: add one on A rising while A leads.
// - Lowest resolution: subtract one on A falling while B leads.
// - Double resolution: count both edges of A only, signed by lead.
// - Full resolution: count every edge of both phases, signed by lead.
// - Each pulse input has its own 32-bit counter over the scan.
// - At scan start capture each counter then clear it, keeping a pulse seen in that same cycle.
// - Pulse counters wrap rather than saturate beyond 2^32 pulses.
// - Each detected pulse adds exactly one to its counter.
// - Adjacent terminal pairs feed the A and B lines of one decoder.
module qpc_quadrature_pulse_counter
   import qpc_pkg::*;
#(
   parameter int NUM_PAIRS = 6
) (
   input wire logic clk, // System clock, 20 MHz.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic [2*NUM_PAIRS-1:0] term_in, // Raw terminal pins.
   input wire logic scan_start, // One-cycle scan boundary strobe.
   input wire logic [2*NUM_PAIRS-1:0][2:0] term_fn, // Requested function per terminal.
   input wire logic [NUM_PAIRS-1:0][1:0] quad_mode, // Resolution per pair.
   output logic [NUM_PAIRS-1:0][QPC_CNT_W-1:0] quad_net, // Signed net count.
   output logic [NUM_PAIRS-1:0] quad_dir_fwd, // Net direction, high when the net count is positive.
   output logic [NUM_PAIRS-1:0][QPC_CNT_W-1:0] quad_fwd, // A-leading total.
   output logic [NUM_PAIRS-1:0][QPC_CNT_W-1:0] quad_rev, // B-leading total.
   output logic [2*NUM_PAIRS-1:0][QPC_CNT_W-1:0] tally_value, // Last scan's pulse count.
   output logic tally_valid, // Pulses high the cycle after scan_start, with the captured counts.
   output logic [NUM_PAIRS-1:0] pair_conflict // Pair assignment conflicts.
);
   localparam int NT = 2 * NUM_PAIRS;

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Three stages; a level is accepted only once stages two and three agree.
   // The agreement filter costs a cycle but keeps a metastable stage from making an edge.
   logic [NT-1:0] s1_q, s2_q, s3_q, lvl_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         lvl_q <= '0;
      end else begin
         s1_q <= term_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
      end
   end
   logic [NT-1:0] lvl_d1_q;
   always_ff @(posedge clk) begin
      if (rst) lvl_d1_q <= '0;
      else lvl_d1_q <= lvl_q;
   end
   wire [NT-1:0] rise = lvl_q & ~lvl_d1_q;

   // ****************************************
   // Pulse counters
   // ****************************************
   logic [NT-1:0][QPC_CNT_W-1:0] tally_q;
   logic valid_q;
   always_ff @(posedge clk) begin
      if (rst) valid_q <= 1'b0;
      else valid_q <= scan_start;
   end
   assign tally_valid = valid_q;

   genvar t;
   generate
      for (t = 0; t < NT; t++) begin : g_tally
         wire active = (term_fn[t] == QPC_FN_EDGE_TALLY);
         // A pulse seen with the strobe opens the new scan, so none is lost at the boundary.
         wire [QPC_CNT_W-1:0] inc = {{(QPC_CNT_W-1){1'b0}}, rise[t] & active};
         always_ff @(posedge clk) begin
            if (rst) begin
               tally_q[t] <= QPC_CNT_RST;
               tally_value[t] <= QPC_CNT_RST;
            end else if (scan_start) begin
               tally_value[t] <= tally_q[t];
               tally_q[t] <= inc;
            end else begin
               tally_q[t] <= tally_q[t] + inc;
            end
         end

         // ****************************************
         // Checks
         // ****************************************
         scan_capture_a: assert property (@(posedge clk) disable iff (rst)
            scan_start |=> tally_value[t] == $past(tally_q[t]) && valid_q)
            else $error("scan capture wrong");
         scan_clear_a: assert property (@(posedge clk) disable iff (rst)
            scan_start |=> tally_q[t] <= 32'h0000_0001)
            else $error("counter not cleared at scan");
         tally_step_a: assert property (@(posedge clk) disable iff (rst)
            (!scan_start && !$past(scan_start))
            |-> (tally_q[t] - $past(tally_q[t])) <= 32'h0000_0001)
            else $error("counter stepped by more than one");
         tally_count_a: assert property (@(posedge clk) disable iff (rst)
            (!scan_start && rise[t] && active)
            |=> tally_q[t] == $past(tally_q[t]) + 32'h0000_0001)
            else $error("pulse not counted once");
      end
   endgenerate

   // ****************************************
   // Quadrature decoders
   // ****************************************
   genvar p;
   generate
      for (p = 0; p < NUM_PAIRS; p++) begin : g_quad
         wire a = lvl_q[2*p];
         wire b = lvl_q[2*p+1];
         wire a_ch = a ^ lvl_d1_q[2*p];
         wire b_ch = b ^ lvl_d1_q[2*p+1];
         wire both = a_ch & b_ch;
         // A leads when, after the change, A differs from B on an A edge, or equals B on a B edge.
         wire a_lead_a = a_ch & ~both & (a != b);
         wire a_lead_b = b_ch & ~both & (a == b);
         wire b_lead_a = a_ch & ~both & (a == b);
         wire b_lead_b = b_ch & ~both & (a != b);
         wire en = (term_fn[2*p] == QPC_FN_QUAD) && (term_fn[2*p+1] == QPC_FN_QUAD);
         logic up, dn;
         always_comb begin
            case (quad_mode[p])
               QPC_MODE_X1: begin
                  up = a_lead_a & a;
                  dn = b_lead_a & ~a;
               end
               QPC_MODE_X2: begin
                  up = a_lead_a;
                  dn = b_lead_a;
               end
               QPC_MODE_X4: begin
                  up = a_lead_a | a_lead_b;
                  dn = b_lead_a | b_lead_b;
               end
               // Code 2 is left unused and counts nothing.
               default: begin
                  up = 1'b0;
                  dn = 1'b0;
               end
            endcase
         end
         // Direction follows the new net value, so a step onto zero reads as not forward.
         wire [QPC_CNT_W-1:0] net_inc = quad_net[p] + 32'h0000_0001;
         wire [QPC_CNT_W-1:0] net_dec = quad_net[p] - 32'h0000_0001;
         wire inc_pos = ~net_inc[QPC_CNT_W-1] & (net_inc != '0);
         wire dec_pos = ~net_dec[QPC_CNT_W-1] & (net_dec != '0);
         always_ff @(posedge clk) begin
            if (rst) begin
               quad_net[p] <= QPC_CNT_RST;
               quad_fwd[p] <= QPC_CNT_RST;
               quad_rev[p] <= QPC_CNT_RST;
               quad_dir_fwd[p] <= 1'b0;
            end else if (en) begin
               if (up) begin
                  quad_net[p] <= net_inc;
                  quad_fwd[p] <= quad_fwd[p] + 32'h0000_0001;
                  quad_dir_fwd[p] <= inc_pos;
               end else if (dn) begin
                  quad_net[p] <= net_dec;
                  quad_rev[p] <= quad_rev[p] + 32'h0000_0001;
                  quad_dir_fwd[p] <= dec_pos;
               end
            end
         end

         // A serial recorder on either terminal excludes the listed partner uses.
         wire ser0 = term_fn[2*p] == QPC_FN_SERIAL_REC;
         wire ser1 = term_fn[2*p+1] == QPC_FN_SERIAL_REC;
         wire bad0 = term_fn[2*p] inside {QPC_FN_EDGE_TALLY, QPC_FN_EDGE_TIMING, QPC_FN_TRIG_WAIT};
         wire bad1 = term_fn[2*p+1] inside {QPC_FN_EDGE_TALLY, QPC_FN_EDGE_TIMING,
                                            QPC_FN_TRIG_WAIT};
         always_ff @(posedge clk) begin
            if (rst) pair_conflict[p] <= 1'b0;
            else pair_conflict[p] <= (ser0 & bad1) | (ser1 & bad0);
         end

         // ****************************************
         // Checks
         // ****************************************
         x1_fall_hold_a: assert property (@(posedge clk) disable iff (rst)
            (en && quad_mode[p] == QPC_MODE_X1 && a_ch && !a) |=> $stable(quad_fwd[p]))
            else $error("x1 counted up on an A fall");
         both_change_a: assert property (@(posedge clk) disable iff (rst)
            both |=> $stable(quad_net[p]))
            else $error("count moved on a double phase change");
         net_balance_a: assert property (@(posedge clk) disable iff (rst)
            (quad_fwd[p] - quad_rev[p]) == quad_net[p])
            else $error("net count does not match totals");
         x4_up_a: assert property (@(posedge clk) disable iff (rst)
            (en && quad_mode[p] == QPC_MODE_X4 && a_lead_b)
            |=> quad_net[p] == $past(quad_net[p]) + 32'h0000_0001)
            else $error("x4 missed a B edge count");
         x2_down_a: assert property (@(posedge clk) disable iff (rst)
            (en && quad_mode[p] == QPC_MODE_X2 && b_lead_a)
            |=> quad_rev[p] == $past(quad_rev[p]) + 32'h0000_0001)
            else $error("x2 missed a reverse count");
         x1_rise_up_a: assert property (@(posedge clk) disable iff (rst)
            (en && quad_mode[p] == QPC_MODE_X1 && a_lead_a && a)
            |=> quad_fwd[p] == $past(quad_fwd[p]) + 32'h0000_0001)
            else $error("x1 missed a forward count");
         x1_fall_down_a: assert property (@(posedge clk) disable iff (rst)
            (en && quad_mode[p] == QPC_MODE_X1 && b_lead_a && !a)
            |=> quad_net[p] == $past(quad_net[p]) - 32'h0000_0001)
            else $error("x1 missed a reverse count");
         x2_up_a: assert property (@(posedge clk) disable iff (rst)
            (en && quad_mode[p] == QPC_MODE_X2 && a_lead_a)
            |=> quad_fwd[p] == $past(quad_fwd[p]) + 32'h0000_0001)
            else $error("x2 missed a forward count");
         dir_sign_a: assert property (@(posedge clk) disable iff (rst)
            quad_dir_fwd[p] == (!quad_net[p][QPC_CNT_W-1] && (quad_net[p] != '0)))
            else $error("direction disagrees with net count");
         idle_hold_a: assert property (@(posedge clk) disable iff (rst)
            !en |=> $stable(quad_net[p]))
            else $error("decoder counted while not paired");
         conflict_flag_a: assert property (@(posedge clk) disable iff (rst)
            ((ser0 && bad1) || (ser1 && bad0)) |=> pair_conflict[p])
            else $error("conflict not flagged");
      end
   endgenerate

endmodule

/* File: inc/qpc_pkg.sv */
// Package for the quadrature decoder and per-scan pulse counters.
// Assumes one 20 MHz system clock and a synchronous active-high reset.
package qpc_pkg;
   // ****************************************
   // Widths and reset values
   // ****************************************
   localparam int QPC_CNT_W = 32;
   localparam int QPC_SYNC_STAGES = 3;
   localparam logic [31:0] QPC_CNT_RST = 32'h0000_0000;
   localparam logic [1:0] QPC_PHASE_RST = 2'h0;

   // ****************************************
   // Counting resolution modes
   // ****************************************
   typedef enum logic [1:0] {
      QPC_MODE_X1 = 2'h0,
      QPC_MODE_X2 = 2'h1,
      QPC_MODE_X4 = 2'h3
   } qpc_mode_t;

   // ****************************************
   // Terminal pair assignments
   // ****************************************
   typedef enum logic [2:0] {
      QPC_FN_IDLE = 3'h0,
      QPC_FN_QUAD = 3'h1,
      QPC_FN_EDGE_TALLY = 3'h2,
      QPC_FN_EDGE_TIMING = 3'h3,
      QPC_FN_SERIAL_REC = 3'h4,
      QPC_FN_TRIG_WAIT = 3'h5
   } qpc_fn_t;
endpackage
